// File: sprite_plane_pkg.sv
// package: register map, field layout, reset values and carrier types of the sprite plane
package sprite_plane_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [19:0] SPRITE_CONTROL_OFFSET = 20'h7_2180; // control register
  localparam logic [19:0] SPRITE_PITCH_OFFSET   = 20'h7_2188; // line pitch
  localparam logic [19:0] SPRITE_POS_OFFSET     = 20'h7_218C; // position
  localparam logic [19:0] SPRITE_SIZE_OFFSET    = 20'h7_2190; // size
  localparam logic [19:0] SPRITE_SCALE_OFFSET   = 20'h7_2194; // scale
  localparam logic [19:0] SPRITE_SURF_OFFSET    = 20'h7_219C; // surface base, arms update

  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int CTL_ENABLE_BIT    = 31;
  localparam int CTL_GAMMA_BIT     = 30;
  localparam int CTL_EXCESS_BIT    = 28;
  localparam int CTL_RANGE_DIS_BIT = 27;
  localparam int CTL_FMT_HI        = 26;
  localparam int CTL_FMT_LO        = 25;
  localparam int CTL_PIPE_CONV_BIT = 24;
  localparam int CTL_SRCKEY_BIT    = 22;
  localparam int CTL_EXTRANGE_BIT  = 21;
  localparam int CTL_ORDER_BIT     = 20;
  localparam int CTL_CONV_DIS_BIT  = 19;
  localparam int CTL_YUV709_BIT    = 18;
  localparam int CTL_BYTEORD_HI    = 17;
  localparam int CTL_BYTEORD_LO    = 16;
  localparam int CTL_ROTATE_BIT    = 15;
  localparam int CTL_TILED_BIT     = 10;
  localparam int CTL_DSTKEY_BIT    = 2;

  // writable bits; all other control positions are reserved and read zero
  localparam logic [31:0] CTL_RW_MASK_BASE = 32'hDF4F_8404; // 21:20 reserved, 22 is keying
  localparam logic [31:0] CTL_RW_MASK_EXT  = 32'hDF7F_8404; // 21:20 writable
  localparam logic [31:0] CTL_RESET        = 32'h0000_0000;
  localparam logic [31:0] PITCH_RW_MASK    = 32'h0000_7FC0; // bits 14:6
  localparam logic [31:0] REG_RESET        = 32'h0000_0000;

  // ------------------------------------------------------------
  // source format and byte order codes
  // ------------------------------------------------------------
  localparam logic [1:0] FMT_YUV422  = 2'b00;
  localparam logic [1:0] FMT_RGB2101 = 2'b01;
  localparam logic [1:0] FMT_BGRX888 = 2'b10;
  localparam logic [1:0] ORD_YUYV    = 2'b00;
  localparam logic [1:0] ORD_UYVY    = 2'b01;
  localparam logic [1:0] ORD_YVYU    = 2'b10;
  localparam logic [1:0] ORD_VYUY    = 2'b11;
  localparam int         BLEND_BPP   = 12; // pixel width entering the blender

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    YUYV_E = 2'b00, UYVY_E = 2'b01, YVYU_E = 2'b10, VYUY_E = 2'b11
  } byte_order_e;

  // decoded datapath steering presented to the plane pipeline
  typedef struct packed {
    logic        enable;         // plane produces pixels
    logic        fetch_en;       // memory fetches allowed
    logic        transparent;    // output forced transparent
    logic        pipe_gamma;     // route through pipe gamma
    logic        pipe_conv;      // route through pipe colour-space converter
    logic        is_yuv;         // source is packed yuv 4:2:2
    logic        is_rgb;         // source is an rgb format
    logic        fmt_reserved;   // reserved format code selected
    logic        rgb_10bit;      // 2:10:10:10 source
    logic        red_low_order;  // red_low_pixel_order chosen
    logic        yuv_convert;    // internal yuv to rgb conversion active
    logic        range_compress; // yuv range compression active
    logic        bt709;          // yuv matrix select
    logic        excess512;      // excess-512 handling
    logic        fit_unit_range; // map source into 0..1 of extended range
    logic        src_key;        // source keying active
    logic        dst_key;        // destination keying active
    logic        rotate180;      // rotation
    logic        tiled;          // tiled surface
    byte_order_e yuv_order;      // yuv byte arrangement
    logic [4:0]  out_bpp;        // bits per pixel into the blender
  } plane_steer_s;

endpackage : sprite_plane_pkg

// File: sprite_ctl_decode.sv
// sprite control decoder: turns the active control word into datapath steering
`timescale 1ns/1ps
`default_nettype none

module sprite_ctl_decode
  import sprite_plane_pkg::*;
#(
  parameter bit EXT_VARIANT = 1'b0 // variant with 2:10:10:10, order and extended range
) (
  input  wire logic [31:0]  ctl_i,          // active control word
  input  wire logic         pipe_ext_range_i, // pipe runs in extended range
  output var plane_steer_s  steer_o         // decoded steering
);

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  wire logic [1:0] fmt       = ctl_i[CTL_FMT_HI:CTL_FMT_LO];
  wire logic       en        = ctl_i[CTL_ENABLE_BIT];
  wire logic       yuv       = (fmt == FMT_YUV422);
  wire logic       blue_low  = (fmt == FMT_BGRX888);
  wire logic       rgb10     = EXT_VARIANT && (fmt == FMT_RGB2101);
  wire logic       rgb       = blue_low | rgb10;
  // 11b always reserved, 01b reserved outside the extended variant
  wire logic       reserved  = !(yuv | rgb);
  // colour order applies only to rgb sources
  wire logic       red_low   = EXT_VARIANT && rgb && ctl_i[CTL_ORDER_BIT];
  wire logic       convert   = yuv && !ctl_i[CTL_CONV_DIS_BIT];
  wire logic       compress  = yuv && !ctl_i[CTL_RANGE_DIS_BIT];
  wire logic       fit_unit  = EXT_VARIANT && pipe_ext_range_i
                               && !ctl_i[CTL_EXTRANGE_BIT];

  // ------------------------------------------------------------
  // steering assembly
  // ------------------------------------------------------------
  assign steer_o.enable         = en;
  assign steer_o.fetch_en       = en;
  assign steer_o.transparent    = !en;
  assign steer_o.pipe_gamma     = ctl_i[CTL_GAMMA_BIT];
  assign steer_o.pipe_conv      = ctl_i[CTL_PIPE_CONV_BIT];
  assign steer_o.is_yuv         = yuv;
  assign steer_o.is_rgb         = rgb;
  assign steer_o.fmt_reserved   = reserved;
  assign steer_o.rgb_10bit      = rgb10;
  assign steer_o.red_low_order  = red_low;
  assign steer_o.yuv_convert    = convert;
  assign steer_o.range_compress = compress;
  assign steer_o.bt709          = yuv && ctl_i[CTL_YUV709_BIT];
  assign steer_o.excess512      = yuv && ctl_i[CTL_EXCESS_BIT];
  assign steer_o.fit_unit_range = fit_unit;
  assign steer_o.src_key        = ctl_i[CTL_SRCKEY_BIT];
  assign steer_o.dst_key        = ctl_i[CTL_DSTKEY_BIT];
  assign steer_o.rotate180      = ctl_i[CTL_ROTATE_BIT];
  assign steer_o.tiled          = ctl_i[CTL_TILED_BIT];
  // byte order only meaningful for yuv; forced to default otherwise
  assign steer_o.yuv_order      = yuv ? byte_order_e'(ctl_i[CTL_BYTEORD_HI:CTL_BYTEORD_LO])
                                      : YUYV_E;
  assign steer_o.out_bpp        = 5'(BLEND_BPP);

endmodule : sprite_ctl_decode

`default_nettype wire

// File: sprite_plane_ctl.sv
// sprite plane control bank: double-buffered registers, arming and pixel keying
// Operation
// - actives load at vblank/pipe-off after arm, or unenabled
// - one plane instance serves exactly one pipe
// - enable bit 31 drives fetch, else transparent
// - enable write held until self-refresh exit done
// - bit 27 clear: yuv range compressed
// - format 00b yuv422, 10b blue-low, others reserved
// - extended variant: 01b is 2:10:10:10 rgb
// - every format leaves as 12 bits per pixel
// - bit 24 routes through pipe colour converter
// - source key makes in-range pixels transparent
// - extended pipe, bit 21 clear: fit 0..1
// - bit 20 picks blue-low or red-low rgb order
// - bit 19 clear: yuv through internal converter
// - bits 17:16 pick one of four yuv orders
`timescale 1ns/1ps
`default_nettype none

module sprite_plane_ctl
  import sprite_plane_pkg::*;
#(
  parameter bit         EXT_VARIANT = 1'b0,     // second device variant
  parameter logic [1:0] PIPE_ID     = 2'h0      // pipe this plane is bound to
) (
  input  wire logic        clk_i,              // display clock, 10 MHz
  input  wire logic        rst_i,              // asynchronous, active high
  // documented register access
  input  wire logic        reg_wr_i,           // write strobe
  input  wire logic        reg_rd_i,           // read strobe
  input  wire logic [19:0] reg_addr_i,         // byte offset
  input  wire logic [31:0] reg_wdata_i,        // write data
  output logic      [31:0] reg_rdata_o,        // read data, registered
  output logic             reg_rvalid_o,       // read data valid pulse
  // pipe status
  input  wire logic        vblank_start_i,     // start of vertical blank pulse
  input  wire logic        pipe_enabled_i,     // pipe running
  input  wire logic        pipe_ext_range_i,   // pipe in extended range
  input  wire logic        sr_exiting_i,       // deep-buffer self-refresh exiting
  // pixel path for keying
  input  wire logic [23:0] pix_i,              // source pixel
  input  wire logic        pix_valid_i,        // source pixel valid
  input  wire logic [23:0] key_min_i,          // key range low
  input  wire logic [23:0] key_max_i,          // key range high
  output logic             pix_transparent_o,  // pixel made transparent
  output logic             pix_valid_o,        // pixel qualifier
  // active settings
  output logic      [31:0] active_ctl_o,       // active control word
  output logic      [31:0] active_pitch_o,     // active line pitch
  output logic      [31:0] active_pos_o,       // active position
  output logic      [31:0] active_size_o,      // active size
  output logic      [31:0] active_scale_o,     // active scale
  output logic      [1:0]  pipe_id_o,          // bound pipe
  output var plane_steer_s steer_o,            // registered steering
  output logic             armed_o             // update armed
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  localparam logic [31:0] CTL_MASK = EXT_VARIANT ? CTL_RW_MASK_EXT : CTL_RW_MASK_BASE;

  wire logic hit_ctl   = reg_addr_i == SPRITE_CONTROL_OFFSET;
  wire logic hit_pitch = reg_addr_i == SPRITE_PITCH_OFFSET;
  wire logic hit_pos   = reg_addr_i == SPRITE_POS_OFFSET;
  wire logic hit_size  = reg_addr_i == SPRITE_SIZE_OFFSET;
  wire logic hit_scale = reg_addr_i == SPRITE_SCALE_OFFSET;
  wire logic hit_surf  = reg_addr_i == SPRITE_SURF_OFFSET;

  // staged (written) copies, used for readback
  logic [31:0] ctl_reg, pitch_reg, pos_reg, size_reg, scale_reg, surf_reg;
  logic [31:0] ctl_next;
  logic        armed_reg;        // surface written, awaiting update point
  logic        hold_en_reg;      // enable write deferred by self-refresh exit

  // ------------------------------------------------------------
  // enable deferral during self-refresh exit
  // ------------------------------------------------------------
  // while exiting, an enabling write keeps the old enable bit staged;
  // the enable is merged in once the exit finishes
  wire logic wr_ctl     = reg_wr_i && hit_ctl;
  wire logic wr_enables = wr_ctl && reg_wdata_i[CTL_ENABLE_BIT] && !ctl_reg[CTL_ENABLE_BIT];
  wire logic defer_en   = wr_enables && sr_exiting_i;
  wire logic release_en = hold_en_reg && !sr_exiting_i;

  always_comb begin
    ctl_next = ctl_reg;
    if (wr_ctl) begin
      ctl_next = reg_wdata_i & CTL_MASK;
      if (defer_en) begin
        ctl_next[CTL_ENABLE_BIT] = 1'b0;
      end
    end
    if (release_en && !(wr_ctl && !reg_wdata_i[CTL_ENABLE_BIT])) begin
      ctl_next[CTL_ENABLE_BIT] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // update point
  // ------------------------------------------------------------
  // sprite not yet enabled: staged values pass through at once
  wire logic not_enabled = !active_ctl_o[CTL_ENABLE_BIT];
  wire logic at_point    = vblank_start_i || !pipe_enabled_i;
  wire logic arm_now     = reg_wr_i && hit_surf;
  wire logic do_update   = (armed_reg && at_point) || not_enabled;

  // ------------------------------------------------------------
  // staged registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_reg     <= CTL_RESET;
      pitch_reg   <= REG_RESET;
      pos_reg     <= REG_RESET;
      size_reg    <= REG_RESET;
      scale_reg   <= REG_RESET;
      surf_reg    <= REG_RESET;
      hold_en_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      if (reg_wr_i && hit_pitch) pitch_reg <= reg_wdata_i & PITCH_RW_MASK;
      if (reg_wr_i && hit_pos)   pos_reg   <= reg_wdata_i;
      if (reg_wr_i && hit_size)  size_reg  <= reg_wdata_i;
      if (reg_wr_i && hit_scale) scale_reg <= reg_wdata_i;
      if (arm_now)               surf_reg  <= reg_wdata_i;
      // a new deferral wins over release in the same cycle
      if (defer_en) begin
        hold_en_reg <= 1'b1;
      end else if (release_en || (wr_ctl && !reg_wdata_i[CTL_ENABLE_BIT])) begin
        hold_en_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // arm flag: set by surface write, cleared at update; set wins
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
    end else if (arm_now) begin
      armed_reg <= 1'b1;
    end else if (do_update) begin
      armed_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // active copies
  // ------------------------------------------------------------
  // the staged values held during this cycle are taken, so a write landing
  // in the same cycle as an update reaches the actives only at a later update
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_ctl_o   <= CTL_RESET;
      active_pitch_o <= REG_RESET;
      active_pos_o   <= REG_RESET;
      active_size_o  <= REG_RESET;
      active_scale_o <= REG_RESET;
    end else if (do_update) begin
      active_ctl_o   <= ctl_reg;
      active_pitch_o <= pitch_reg;
      active_pos_o   <= pos_reg;
      active_size_o  <= size_reg;
      active_scale_o <= scale_reg;
    end
  end

  // ------------------------------------------------------------
  // steering decode and registration
  // ------------------------------------------------------------
  plane_steer_s steer_w;

  sprite_ctl_decode #(
    .EXT_VARIANT (EXT_VARIANT)
  ) u_decode (
    .ctl_i            (active_ctl_o),
    .pipe_ext_range_i (pipe_ext_range_i),
    .steer_o          (steer_w)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      steer_o   <= '0;
      pipe_id_o <= 2'h0;
      armed_o   <= 1'b0;
    end else begin
      steer_o   <= steer_w;
      pipe_id_o <= PIPE_ID;
      armed_o   <= armed_reg;
    end
  end

  // ------------------------------------------------------------
  // source keying
  // ------------------------------------------------------------
  // key compare is per channel inclusive range; destination keying is
  // handled by the blender and not combined here
  function automatic logic in_range(input logic [23:0] p, lo, hi);
    in_range = (p[23:16] >= lo[23:16]) && (p[23:16] <= hi[23:16]) &&
               (p[15:8]  >= lo[15:8])  && (p[15:8]  <= hi[15:8])  &&
               (p[7:0]   >= lo[7:0])   && (p[7:0]   <= hi[7:0]);
  endfunction : in_range

  wire logic key_hit = steer_w.src_key && in_range(pix_i, key_min_i, key_max_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pix_transparent_o <= 1'b1;
      pix_valid_o       <= 1'b0;
    end else begin
      pix_valid_o       <= pix_valid_i && steer_w.fetch_en;
      pix_transparent_o <= steer_w.transparent || key_hit;
    end
  end

  // ------------------------------------------------------------
  // readback: staged values; unmapped offsets read zero
  // ------------------------------------------------------------
  wire logic [31:0] rd_mux = hit_ctl   ? ctl_reg   :
                             hit_pitch ? pitch_reg :
                             hit_pos   ? pos_reg   :
                             hit_size  ? size_reg  :
                             hit_scale ? scale_reg :
                             hit_surf  ? surf_reg  : 32'h0000_0000;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 32'h0000_0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      reg_rdata_o  <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : sprite_plane_ctl

`default_nettype wire

// File: sprite_plane_ctl_properties.sv
// concurrent checks on the ports of the sprite plane control bank
`timescale 1ns/1ps
`default_nettype none
module sprite_plane_ctl_properties
  import sprite_plane_pkg::*;
#(
  parameter bit         EXT_VARIANT = 1'b0, // variant, handed on from the design
  parameter logic [1:0] PIPE_ID     = 2'h0  // bound pipe, handed on from the design
) (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         reg_rd_i,
  input wire logic [19:0]  reg_addr_i,
  input wire logic [31:0]  reg_rdata_o,
  input wire logic         reg_rvalid_o,
  input wire logic         vblank_start_i,
  input wire logic         pipe_enabled_i,
  input wire logic         sr_exiting_i,
  input wire logic         pix_valid_i,
  input wire logic         pix_transparent_o,
  input wire logic         pix_valid_o,
  input wire logic [31:0]  active_ctl_o,
  input wire logic [1:0]   pipe_id_o,
  input wire plane_steer_s steer_o
);
  // reserved control positions differ between the two variants
  localparam logic [31:0] RSV = EXT_VARIANT ? ~CTL_RW_MASK_EXT : ~CTL_RW_MASK_BASE;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  // control read, answered one cycle later
  sequence s_ctl_read;
    reg_rd_i && reg_addr_i == SPRITE_CONTROL_OFFSET ##1 reg_rvalid_o;
  endsequence
  // plane live for two cycles with no update point offered
  sequence s_no_update;
    (!vblank_start_i && pipe_enabled_i && active_ctl_o[CTL_ENABLE_BIT]) [*2];
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_pipe_bound: assert property (!$past(rst_i) |-> pipe_id_o == PIPE_ID)
    else $error("pipe binding differs from parameter");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 20'h7_2184
    |=> reg_rdata_o == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_reserved_zero: assert property (s_ctl_read |-> (reg_rdata_o & RSV) == 32'h0)
    else $error("reserved control bits read nonzero");
  a_active_hold: assert property (s_no_update |=> $stable(active_ctl_o))
    else $error("active control changed without update point");
  a_disabled_clear: assert property (!active_ctl_o[CTL_ENABLE_BIT]
    |=> pix_transparent_o)
    else $error("disabled plane output not transparent");
  a_valid_gate: assert property (pix_valid_o
    |-> $past(pix_valid_i) && $past(active_ctl_o[31]))
    else $error("pixel valid without enabled plane");
  a_route_bits: assert property (
    steer_o.pipe_gamma == $past(active_ctl_o[CTL_GAMMA_BIT])
    && steer_o.pipe_conv == $past(active_ctl_o[CTL_PIPE_CONV_BIT]))
    else $error("pipe routing differs from active control");
  a_blend_width: assert property (steer_o.enable |-> steer_o.out_bpp == BLEND_BPP)
    else $error("blender pixel width wrong");
  a_conv_select: assert property (steer_o.is_yuv |->
    steer_o.yuv_convert == !$past(active_ctl_o[CTL_CONV_DIS_BIT]))
    else $error("internal converter selection wrong");
  a_sr_defer: assert property ($past(sr_exiting_i) && $past(sr_exiting_i, 2)
    && !$past(active_ctl_o[CTL_ENABLE_BIT]) |-> !active_ctl_o[CTL_ENABLE_BIT])
    else $error("plane enabled during self-refresh exit");
endmodule : sprite_plane_ctl_properties

bind sprite_plane_ctl sprite_plane_ctl_properties #(.EXT_VARIANT(EXT_VARIANT), .PIPE_ID(PIPE_ID))
  u_props (.clk_i(clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .vblank_start_i(vblank_start_i),
  .pipe_enabled_i(pipe_enabled_i), .sr_exiting_i(sr_exiting_i), .pix_valid_i(pix_valid_i),
  .pix_transparent_o(pix_transparent_o), .pix_valid_o(pix_valid_o),
  .active_ctl_o(active_ctl_o), .pipe_id_o(pipe_id_o), .steer_o(steer_o));
`default_nettype wire

// File: sprite_plane_ctl_tb.sv
// self-checking testbench of the sprite plane control bank
`timescale 1ns/1ps
`default_nettype none
module sprite_plane_ctl_tb
  import sprite_plane_pkg::*;
;
  logic         clk_i, rst_i, reg_wr_i, reg_rd_i, vblank_start_i, pipe_enabled_i;
  logic         pipe_ext_range_i, sr_exiting_i, pix_valid_i, k;
  logic [19:0]  reg_addr_i;
  logic [31:0]  reg_wdata_i, m_stage, m_act, v;   // bench model: staged and active control
  logic [23:0]  pix_i, key_min_i, key_max_i;
  wire  [31:0]  reg_rdata_o, active_ctl_o, active_pitch_o, active_pos_o, active_size_o;
  wire  [31:0]  active_scale_o;
  wire          reg_rvalid_o, pix_transparent_o, pix_valid_o, armed_o;
  wire  [1:0]   pipe_id_o;
  plane_steer_s steer_o;
  integer       seed = 32'h1b41;
  int           failures = 0, num_checks = 0, i, c;

  sprite_plane_ctl #(.EXT_VARIANT(1'b0), .PIPE_ID(2'h1)) u_sprite_plane_ctl (
    .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .vblank_start_i(vblank_start_i),
    .pipe_enabled_i(pipe_enabled_i), .pipe_ext_range_i(pipe_ext_range_i),
    .sr_exiting_i(sr_exiting_i), .pix_i(pix_i), .pix_valid_i(pix_valid_i),
    .key_min_i(key_min_i), .key_max_i(key_max_i), .pix_transparent_o(pix_transparent_o),
    .pix_valid_o(pix_valid_o), .active_ctl_o(active_ctl_o), .active_pitch_o(active_pitch_o),
    .active_pos_o(active_pos_o), .active_size_o(active_size_o),
    .active_scale_o(active_scale_o), .pipe_id_o(pipe_id_o), .steer_o(steer_o),
    .armed_o(armed_o));

  // ------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // a hang counts as a failure
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    end_sim();
  end
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // inputs move 1 ns after the edge so no race with sampling
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // strobes drop a full cycle between calls
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick();
    reg_wr_i = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [19:0] a, input logic [31:0] exp, input string what);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    tick();
    reg_rd_i = 1'b0;
    cmp("rvalid", 1'b1, reg_rvalid_o);
    cmp(what, exp, reg_rdata_o);
    tick();
  endtask : rd
  // one update point: start of blank, or a one-cycle pipe drop
  task automatic strobe(input bit blank);
    if (blank) vblank_start_i = 1'b1;
    else pipe_enabled_i = 1'b0;
    tick();
    vblank_start_i = 1'b0;
    pipe_enabled_i = 1'b1;
    tick();
    tick();
  endtask : strobe
  task automatic chk_steer();
    logic y, r;
    y = m_act[26:25] == FMT_YUV422;
    r = m_act[26:25] == FMT_BGRX888;
    cmp("enable", m_act[31], steer_o.enable);
    cmp("fetch", m_act[31], steer_o.fetch_en);
    cmp("transparent", !m_act[31], steer_o.transparent);
    cmp("is_yuv", y, steer_o.is_yuv);
    cmp("fmt_reserved", m_act[25], steer_o.fmt_reserved);
    cmp("src_key", m_act[22], steer_o.src_key);
    if (y) cmp("order", m_act[17:16], steer_o.yuv_order);
    if (y && !m_act[19]) cmp("range", !m_act[27], steer_o.range_compress);
    if (r) cmp("is_rgb", 1'b1, steer_o.is_rgb);
    if (r) cmp("range_rgb", 1'b0, steer_o.range_compress);
    if (r) cmp("red_low", 1'b0, steer_o.red_low_order);
  endtask : chk_steer
  // write control, arm, then offer blank
  task automatic load_ctl(input logic [31:0] d);
    logic live;
    live = m_act[31];
    wr(SPRITE_CONTROL_OFFSET, d);
    m_stage = d & CTL_RW_MASK_BASE;
    if (!live) m_act = m_stage;
    wr(SPRITE_SURF_OFFSET, 32'h0010_0000);
    cmp("active_hold", m_act, active_ctl_o);
    if (live) cmp("armed", 1'b1, armed_o);
    strobe(1'b1);
    m_act = m_stage;
    cmp("active_ctl", m_act, active_ctl_o);
    cmp("disarmed", 1'b0, armed_o);
    chk_steer();
  endtask : load_ctl

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {reg_wr_i, reg_rd_i, vblank_start_i, sr_exiting_i, pix_valid_i, pipe_ext_range_i} = '0;
    pipe_enabled_i = 1'b1;
    rst_i = 1'b1;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    pix_i = '0;
    key_min_i = 24'h20_2020;
    key_max_i = 24'hC0_C0C0;
    m_stage = '0;
    m_act = '0;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    cmp("rst_transp", 1'b1, pix_transparent_o);
    tick();
    cmp("pipe_id", 2'h1, pipe_id_o);
    rd(SPRITE_CONTROL_OFFSET, CTL_RESET, "ctl_reset");
    rd(20'h7_2184, 32'h0, "unmapped");
    load_ctl(32'hFFFF_FFFB);
    rd(SPRITE_CONTROL_OFFSET, m_stage, "ctl_mask");
    wr(SPRITE_PITCH_OFFSET, 32'hFFFF_FFFF);
    rd(SPRITE_PITCH_OFFSET, PITCH_RW_MASK, "pitch_mask");
    cmp("pitch_hold", REG_RESET, active_pitch_o);
    for (i = 0; i < 3; i++) wr(20'(SPRITE_POS_OFFSET + 4 * i), 32'h0012_0034 + i);
    load_ctl(m_stage);
    cmp("pitch_active", PITCH_RW_MASK, active_pitch_o);
    cmp("pos", 32'h0012_0034, active_pos_o);
    cmp("size", 32'h0012_0035, active_size_o);
    cmp("scale", 32'h0012_0036, active_scale_o);
    for (i = 0; i < 16; i++) begin
      v = $random(seed);
      v[26:25] = i[1:0];
      v[17:16] = i[3:2];
      v[31] = (i != 5);
      v[2] = v[2] & !v[22];
      load_ctl(v);
    end
    // no arm, no update; then the pipe drop acts as update point
    wr(SPRITE_CONTROL_OFFSET, 32'h8100_0000);
    strobe(1'b1);
    cmp("no_arm", m_act, active_ctl_o);
    wr(SPRITE_SURF_OFFSET, 32'h0020_0000);
    strobe(1'b0);
    m_act = 32'h8100_0000;
    cmp("pipe_off_update", m_act, active_ctl_o);
    // enable written during self-refresh exit waits for the exit
    load_ctl(32'h0000_0000);
    sr_exiting_i = 1'b1;
    wr(SPRITE_CONTROL_OFFSET, 32'h8000_0000);
    tick();
    tick();
    cmp("sr_hold", 1'b0, active_ctl_o[31]);
    sr_exiting_i = 1'b0;
    repeat (4) tick();
    cmp("sr_apply", 1'b1, active_ctl_o[31]);
    m_act = 32'h8000_0000;
    // source keying on a blue-low rgb plane, one exact-match pixel
    load_ctl(32'h8440_0000);
    pix_valid_i = 1'b1;
    for (i = 0; i < 24; i++) begin
      pix_i = 24'($random(seed));
      key_min_i = (i == 3) ? pix_i : 24'h20_2020;
      key_max_i = (i == 3) ? pix_i : 24'hC0_C0C0;
      tick();
      k = 1'b1;
      for (c = 0; c < 3; c++) k &= pix_i[c*8+:8] >= key_min_i[c*8+:8]
        && pix_i[c*8+:8] <= key_max_i[c*8+:8];
      cmp("key", k, pix_transparent_o);
      cmp("pix_valid", 1'b1, pix_valid_o);
    end
    load_ctl(32'h0000_0000);
    cmp("off_transp", 1'b1, pix_transparent_o);
    cmp("off_valid", 1'b0, pix_valid_o);
    end_sim();
  end
endmodule : sprite_plane_ctl_tb
`default_nettype wire
